/* File: light_proximity_sequencer.sv */
`timescale 1ns/10ps
// What this block does
// - start in power-down, no conversion until a measurement is commanded
// - result registers read zero until the first conversion completes
// - single-shot mode converts once then returns to power-down itself
// - single-shot result stays readable until a later conversion overwrites
// - continuous mode converts back to back, updating result each time
// - power-down command stops a running continuous measurement
// - integration timed by counting oscillator cycles, n of 4, 8, 12 or 16
// - results are unsigned n-bit values, at most 16 bits
// - six modes: once and continuous ambient, IR, proximity, programmable in series
// - LED driver output enabled only during a proximity measurement
// - drive strength code 0..3 selects 100, 50, 25, 12.5 mA
// - modulation bit 0 gives steady drive, 1 switches at 360 kHz
// - modulated LED drive has 50 percent duty cycle
// - host selects range 1 through range 4
// - interrupt pin is active low open drain
// - interrupt state readable as a status bit over the bus
// - interrupt when result above upper or below lower threshold
// - excursion flagged only after the programmed number (1 to 16) of consecutive out-of-window cycles
// - mode field: 0 off, 1-3 once, 4 reserved, 5-7 continuous
// - persistence codes 0..3 require 1, 4, 8 or 16 cycles
// - pin and status bit stay set until first command register transfer ends
// - upper and lower thresholds are 16 bits, two writable bytes each
module light_proximity_sequencer
(
  input  wire logic                          CLOCK,
  input  wire logic                          NRST,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [lps_pkg::ADDR_W-1:0]    PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  input  wire logic                          OSC_CLK,
  input  wire logic                          ADC_PULSE,
  output logic                               ADC_ACTIVE,
  output logic      [1:0]                    SENSE_CHANNEL,
  output logic      [1:0]                    RANGE_SELECT,
  output logic                               PROX_SCHEME,
  output logic      [3:0]                    RESOLUTION_N,
  output logic                               IR_LED_DRIVE_OUTPUT,
  output logic      [1:0]                    LED_DRIVE_STRENGTH,
  output logic                               INT_N_O,
  output logic                               INT_N_OE
);

  // n-bit width selected by the resolution code
  function automatic logic [4:0] res_bits(input logic [1:0] code);
    logic [4:0] n;
    n = 5'h10;
    unique case (code)
      2'h0: n = 5'h10;
      2'h1: n = 5'h0c;
      2'h2: n = 5'h08;
      2'h3: n = 5'h04;
    endcase
    return n;
  endfunction

  // consecutive out-of-window results needed before flagging
  function automatic logic [lps_pkg::PERS_W-1:0] persist_need(input logic [1:0] code);
    logic [lps_pkg::PERS_W-1:0] m;
    m = 5'h01;
    unique case (code)
      2'h0: m = 5'h01;
      2'h1: m = 5'h04;
      2'h2: m = 5'h08;
      2'h3: m = 5'h10;
    endcase
    return m;
  endfunction

  function automatic logic mode_runs(input logic [2:0] m);
    return (m != lps_pkg::MODE_OFF) && (m != lps_pkg::MODE_RSVD);
  endfunction

  localparam logic [4:0] MOD_LAST = 5'(lps_pkg::MOD_HALF_CYC - 1);
  logic [2:0]                    mode_reg;
  logic [1:0]                    persist_reg;
  logic                          flag_reg;
  logic [7:0]                    cmd2_reg;
  logic [15:0]                   data_reg;
  logic [15:0]                   thr_lo_reg;
  logic [15:0]                   thr_hi_reg;
  logic                          pready_reg;
  logic                          pslverr_reg;
  logic [31:0]                   prdata_reg;
  logic                          restart_reg;
  lps_pkg::seq_state_t           state_reg;
  logic [15:0]                   int_cnt_reg;
  logic [15:0]                   pulse_cnt_reg;
  logic [lps_pkg::PERS_W-1:0]    pers_cnt_reg;
  logic                          osc_meta_reg;
  logic                          osc_sync_reg;
  logic                          osc_prev_reg;
  logic                          adc_meta_reg;
  logic                          adc_sync_reg;
  logic                          adc_prev_reg;
  logic [4:0]                    mod_cnt_reg;
  logic                          mod_phase_reg;
  logic                          led_reg;
  logic [1:0]                    strength_reg;
  logic                          active_reg;
  logic [1:0]                    channel_reg;
  logic [3:0]                    res_n_reg;
  logic                          int_o_reg;

  logic [2:0]  idx;
  logic        mapped;
  logic        setup;
  logic        acc;
  logic        wr;
  logic        osc_rise;
  logic        adc_rise;
  logic [15:0] last_cnt;
  logic        conv_done;
  logic        out_of_window;
  logic [lps_pkg::PERS_W-1:0] pers_next;
  logic [31:0] rd_mux;

  assign idx      = PADDR[lps_pkg::IDX_MSB:lps_pkg::IDX_LSB];
  assign mapped   = (PADDR[1:0] == 2'h0) && (PADDR[lps_pkg::ADDR_W-1:lps_pkg::IDX_MSB+1] == '0);
  assign setup    = PSEL && PENABLE && !pready_reg;
  assign acc      = PSEL && PENABLE && pready_reg;
  assign wr       = acc && PWRITE && mapped;
  assign osc_rise = osc_sync_reg && !osc_prev_reg;
  assign adc_rise = adc_sync_reg && !adc_prev_reg;
  assign last_cnt = 16'hffff >> (5'h10 - res_bits(cmd2_reg[lps_pkg::RES_LSB +: 2]));

  assign conv_done = (state_reg == lps_pkg::ST_INTEG) && !restart_reg && osc_rise
                     && (int_cnt_reg == last_cnt);

  assign out_of_window = (pulse_cnt_reg > thr_hi_reg) || (pulse_cnt_reg < thr_lo_reg);
  assign pers_next     = (pers_cnt_reg == persist_need(2'h3)) ? pers_cnt_reg
                                                              : pers_cnt_reg + 5'h01;

  // apb: one wait state so that read data comes from a flop
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      pready_reg <= 1'b0;
    else
      pready_reg <= setup;
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      lps_pkg::IDX_CMD1: rd_mux[7:0] = {mode_reg, 2'h0, flag_reg, persist_reg};
      lps_pkg::IDX_CMD2: rd_mux[7:0] = cmd2_reg;
      lps_pkg::IDX_DLSB: rd_mux[7:0] = data_reg[7:0];
      lps_pkg::IDX_DMSB: rd_mux[7:0] = data_reg[15:8];
      lps_pkg::IDX_TLL:  rd_mux[7:0] = thr_lo_reg[7:0];
      lps_pkg::IDX_TLM:  rd_mux[7:0] = thr_lo_reg[15:8];
      lps_pkg::IDX_THL:  rd_mux[7:0] = thr_hi_reg[7:0];
      lps_pkg::IDX_THM:  rd_mux[7:0] = thr_hi_reg[15:8];
    endcase
    if (!mapped)
      rd_mux = 32'h0000_0000;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      prdata_reg  <= PWRITE ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= !mapped;
    end
    else if (acc)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  // command registers come up in power-down
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      mode_reg    <= lps_pkg::CMD_RST[lps_pkg::MODE_LSB +: 3];
      persist_reg <= lps_pkg::CMD_RST[lps_pkg::PRST_LSB +: 2];
      cmd2_reg    <= lps_pkg::CMD_RST;
    end
    else if (wr && idx == lps_pkg::IDX_CMD1)
    begin
      mode_reg    <= PWDATA[lps_pkg::MODE_LSB +: 3];
      persist_reg <= PWDATA[lps_pkg::PRST_LSB +: 2];
    end
    else if (wr && idx == lps_pkg::IDX_CMD2)
      cmd2_reg <= PWDATA[7:0];
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      thr_lo_reg <= lps_pkg::THR_LO_RST;
      thr_hi_reg <= lps_pkg::THR_HI_RST;
    end
    else if (wr)
    begin
      if (idx == lps_pkg::IDX_TLL)
        thr_lo_reg[7:0] <= PWDATA[7:0];
      if (idx == lps_pkg::IDX_TLM)
        thr_lo_reg[15:8] <= PWDATA[7:0];
      if (idx == lps_pkg::IDX_THL)
        thr_hi_reg[7:0] <= PWDATA[7:0];
      if (idx == lps_pkg::IDX_THM)
        thr_hi_reg[15:8] <= PWDATA[7:0];
    end
  end

  // first command register write, or second during integration, restarts the sequencer next cycle
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      restart_reg <= 1'b0;
    else
      restart_reg <= wr && (idx == lps_pkg::IDX_CMD1
                     || (idx == lps_pkg::IDX_CMD2 && state_reg == lps_pkg::ST_INTEG));
  end

  // oscillator and converter pulse synchronisers
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      adc_meta_reg <= 1'b0;
      adc_sync_reg <= 1'b0;
      adc_prev_reg <= 1'b0;
    end
    else
    begin
      osc_meta_reg <= OSC_CLK;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
      adc_meta_reg <= ADC_PULSE;
      adc_sync_reg <= adc_meta_reg;
      adc_prev_reg <= adc_sync_reg;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      state_reg <= lps_pkg::ST_OFF;
    else if (restart_reg)
      // power-down or reserved code stops conversion
      state_reg <= mode_runs(mode_reg) ? lps_pkg::ST_INTEG : lps_pkg::ST_OFF;
    else if (conv_done && !mode_reg[lps_pkg::MODE_CONT_BIT])
      state_reg <= lps_pkg::ST_OFF;
  end

  // integration and converter pulse counters
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      int_cnt_reg   <= 16'h0000;
      pulse_cnt_reg <= 16'h0000;
    end
    else if (restart_reg || conv_done || state_reg == lps_pkg::ST_OFF)
    begin
      int_cnt_reg   <= 16'h0000;
      pulse_cnt_reg <= 16'h0000;
    end
    else
    begin
      if (osc_rise)
        int_cnt_reg <= int_cnt_reg + 16'h0001;
      // saturate at the n-bit full scale
      if (adc_rise && pulse_cnt_reg != last_cnt)
        pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      data_reg <= lps_pkg::DATA_RST;
    // overwritten only by a finished conversion
    else if (conv_done)
      data_reg <= pulse_cnt_reg;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      pers_cnt_reg <= '0;
    else if (conv_done)
      pers_cnt_reg <= out_of_window ? pers_next : '0;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      flag_reg <= 1'b0;
    // set after m consecutive excursions; set beats clear
    else if (conv_done && out_of_window && pers_next >= persist_need(persist_reg))
      flag_reg <= 1'b1;
    // cleared at end of a first command register transfer
    else if (acc && mapped && idx == lps_pkg::IDX_CMD1)
      flag_reg <= 1'b0;
  end

  // 360 kHz square wave, equal halves
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      mod_cnt_reg   <= 5'h00;
      mod_phase_reg <= 1'b1;
    end
    else if (state_reg == lps_pkg::ST_OFF || restart_reg)
    begin
      mod_cnt_reg   <= 5'h00;
      mod_phase_reg <= 1'b1;
    end
    else if (mod_cnt_reg == MOD_LAST)
    begin
      mod_cnt_reg   <= 5'h00;
      mod_phase_reg <= !mod_phase_reg;
    end
    else
      mod_cnt_reg <= mod_cnt_reg + 5'h01;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      led_reg      <= 1'b0;
      strength_reg <= 2'h0;
      active_reg   <= 1'b0;
      channel_reg  <= lps_pkg::CH_AMBIENT;
      res_n_reg    <= 4'h0;
    end
    else
    begin
      active_reg  <= (state_reg == lps_pkg::ST_INTEG) && !restart_reg;
      channel_reg <= mode_reg[1:0] - 2'h1;
      led_reg <= (state_reg == lps_pkg::ST_INTEG) && !restart_reg
                 && (mode_reg[1:0] - 2'h1 == lps_pkg::CH_PROX)
                 && (!cmd2_reg[lps_pkg::FREQ_BIT] || mod_phase_reg);
      // code passed to current source; code 0 is strongest
      strength_reg <= cmd2_reg[lps_pkg::IS_LSB +: 2];
      res_n_reg    <= 4'(res_bits(cmd2_reg[lps_pkg::RES_LSB +: 2]));
    end
  end

  // open drain: data always low, enable pulls the pin
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      int_o_reg <= 1'b0;
    else
      int_o_reg <= 1'b0;
  end

  assign PRDATA              = prdata_reg;
  assign PREADY              = pready_reg;
  assign PSLVERR             = pslverr_reg;
  assign ADC_ACTIVE          = active_reg;
  assign SENSE_CHANNEL       = channel_reg;
  assign RANGE_SELECT        = cmd2_reg[lps_pkg::RANGE_LSB +: 2];
  assign PROX_SCHEME         = cmd2_reg[lps_pkg::SCHEME_BIT];
  assign RESOLUTION_N        = res_n_reg;
  assign IR_LED_DRIVE_OUTPUT = led_reg;
  assign LED_DRIVE_STRENGTH  = strength_reg;
  assign INT_N_O             = int_o_reg;
  // pin enable is the readable status bit
  assign INT_N_OE            = flag_reg;
endmodule

/* File: light_proximity_sequencer_bench.sv */
`timescale 1ns/10ps
module light_proximity_sequencer_bench;
  typedef struct packed {logic [7:0] c1; logic [7:0] c2; logic [3:0] k; logic [1:0] ch;} row_t;
  logic        CLOCK, NRST, PSEL, PENABLE, PWRITE, OSC_CLK, ADC_PULSE, stream, err;
  logic        PREADY, PSLVERR, ADC_ACTIVE, PROX_SCHEME, IR_LED_DRIVE_OUTPUT, INT_N_O, INT_N_OE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0]  burst, RESOLUTION_N;
  logic [1:0]  SENSE_CHANNEL, RANGE_SELECT, LED_DRIVE_STRENGTH;
  int          bad_count, check_count, run, max_run, led_seen, i, t;
  row_t        rows [4];

  light_proximity_sequencer dut (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OSC_CLK(OSC_CLK), .ADC_PULSE(ADC_PULSE), .ADC_ACTIVE(ADC_ACTIVE),
    .SENSE_CHANNEL(SENSE_CHANNEL), .RANGE_SELECT(RANGE_SELECT), .PROX_SCHEME(PROX_SCHEME),
    .RESOLUTION_N(RESOLUTION_N), .IR_LED_DRIVE_OUTPUT(IR_LED_DRIVE_OUTPUT),
    .LED_DRIVE_STRENGTH(LED_DRIVE_STRENGTH), .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE));
  lps_frontend fe (.active(ADC_ACTIVE), .burst(burst), .stream(stream), .OSC_CLK(OSC_CLK),
    .ADC_PULSE(ADC_PULSE));

  initial
  begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK)
  begin
    run = (IR_LED_DRIVE_OUTPUT === 1'b1) ? run + 1 : 0;
    if (run > max_run)
      max_run = run;
    if (run > 0)
      led_seen = 1;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chk_in(input string what, input logic [31:0] lo, input logic [31:0] hi,
              input logic [31:0] got);
    check_count++;
    if (!(got >= lo && got <= hi))
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask

  // master waits for pready with no assumed latency
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h00_0000, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do
      @(posedge CLOCK);
    while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wait_act(input logic lvl);
    t = 0;
    while (ADC_ACTIVE !== lvl && t < 2000)
    begin
      @(posedge CLOCK);
      t++;
    end
    chk("adc_active", lvl, ADC_ACTIVE);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #1000000;
    bad_count++;
    end_of_test;
  end

  initial
  begin
    rows = '{{8'h20, 8'h0C, 4'h3, 2'h0}, {8'h40, 8'hBF, 4'h8, 2'h1},
             {8'h60, 8'h1D, 4'h5, 2'h2}, {8'h60, 8'h6E, 4'h0, 2'h2}};
    {PSEL, PENABLE, PWRITE, NRST, stream} = 5'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    burst = 4'h0;
    bad_count = 0;
    check_count = 0;
    run = 0;
    repeat (20) @(posedge CLOCK);
    NRST <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(i * 4), 8'h00);
      chk("reset reg", (i > 5) ? 32'h0000_00ff : 32'h0000_0000, rd);
    end
    chk("idle", 1'b0, ADC_ACTIVE);
    apb(1'b1, 8'h00, 8'h80);
    repeat (20) @(posedge CLOCK);
    chk("reserved mode", 1'b0, ADC_ACTIVE);
    apb(1'b1, 8'h22, 8'h55);
    chk("slverr", 1'b1, err);
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped read", 32'h0000_0000, rd);
    apb(1'b1, 8'h08, 8'h77);
    apb(1'b0, 8'h08, 8'h00);
    chk("data read only", 32'h0000_0000, rd);
    apb(1'b1, 8'h10, 8'h5A);
    apb(1'b0, 8'h10, 8'h00);
    chk("threshold", 32'h0000_005a, rd);
    apb(1'b1, 8'h10, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      burst <= rows[i].k;
      apb(1'b1, 8'h04, rows[i].c2);
      repeat (2) @(posedge CLOCK);
      chk("range", rows[i].c2[1:0], RANGE_SELECT);
      chk("strength", rows[i].c2[5:4], LED_DRIVE_STRENGTH);
      chk("scheme", rows[i].c2[7], PROX_SCHEME);
      chk("resolution", 4'h4, RESOLUTION_N);
      apb(1'b1, 8'h00, rows[i].c1);
      wait_act(1'b1);
      chk("channel", rows[i].ch, SENSE_CHANNEL);
      max_run = 0;
      led_seen = 0;
      wait_act(1'b0);
      chk("led used", rows[i].ch == 2'h2, led_seen);
      if (rows[i].c2[6])
        chk("half period", 27, max_run);
      else if (rows[i].ch == 2'h2)
        chk_in("steady drive", 28, 1000, max_run);
      repeat (200) @(posedge CLOCK);
      chk("stays off", 1'b0, ADC_ACTIVE);
      apb(1'b0, 8'h08, 8'h00);
      chk("data lsb", rows[i].k, rd);
      apb(1'b0, 8'h0C, 8'h00);
      chk("data msb", 32'h0000_0000, rd);
      $display("test row %0d done", i);
    end
    apb(1'b1, 8'h18, 8'h04);
    apb(1'b1, 8'h1C, 8'h00);
    stream <= 1'b1;
    apb(1'b1, 8'h04, 8'h0C);
    apb(1'b1, 8'h00, 8'hA1);
    #18000;
    chk("early interrupt", 1'b0, INT_N_OE);
    #14000;
    chk("upper interrupt", 1'b1, INT_N_OE);
    apb(1'b0, 8'h00, 8'h00);
    chk("flag bit", 32'h0000_00a5, rd);
    apb(1'b0, 8'h08, 8'h00);
    chk_in("running data", 14, 18, rd);
    apb(1'b1, 8'h00, 8'h00);
    repeat (400) @(posedge CLOCK);
    chk("interrupt cleared", 1'b0, INT_N_OE);
    chk("stopped", 1'b0, ADC_ACTIVE);
    $display("test upper window done");
    stream <= 1'b0;
    apb(1'b1, 8'h10, 8'h04);
    apb(1'b1, 8'h18, 8'hFF);
    apb(1'b1, 8'h00, 8'hA0);
    #9000;
    chk("lower interrupt", 1'b1, INT_N_OE);
    apb(1'b1, 8'h00, 8'h00);
    $display("test lower window done");
    end_of_test;
  end
endmodule

/* File: lps_checker_assertions.sv */
`timescale 1ns/10ps
module lps_checker
(
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        ADC_ACTIVE,
  input wire logic [1:0]  SENSE_CHANNEL,
  input wire logic        IR_LED_DRIVE_OUTPUT,
  input wire logic        INT_N_O,
  input wire logic        INT_N_OE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  wire acc = PSEL && PENABLE && PREADY;
  wire cmd1 = acc && PADDR == 8'h00;

  wait_state_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("pready not after one wait state");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  err_map_a: assert property (PREADY |-> PSLVERR == (PADDR[1:0] != 2'h0 || PADDR[7:5] != 3'h0))
    else $error("pslverr does not match address map");
  reset_idle_a: assert property (
    disable iff (1'b0) !NRST |=> !ADC_ACTIVE && !INT_N_OE && !IR_LED_DRIVE_OUTPUT)
    else $error("activity during reset");
  run_start_a: assert property (
    cmd1 && PWRITE && PWDATA[6:5] != 2'h0 |-> ##[1:3] ADC_ACTIVE)
    else $error("no conversion after mode write");
  halt_a: assert property (
    cmd1 && PWRITE && PWDATA[6:5] == 2'h0 |-> ##[1:3] !ADC_ACTIVE)
    else $error("conversion runs after power-down");
  led_prox_a: assert property (
    IR_LED_DRIVE_OUTPUT |-> ADC_ACTIVE && SENSE_CHANNEL == 2'h2)
    else $error("led driven outside proximity");
  open_drain_a: assert property (!INT_N_O)
    else $error("interrupt pin driven high");
  flag_hold_a: assert property ($fell(INT_N_OE) |-> $past(cmd1))
    else $error("interrupt cleared without command access");
  flag_read_a: assert property (
    cmd1 && !PWRITE |-> PRDATA[2] == $past(INT_N_OE))
    else $error("status bit differs from pin");
endmodule

bind light_proximity_sequencer lps_checker chk (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_ACTIVE(ADC_ACTIVE), .SENSE_CHANNEL(SENSE_CHANNEL),
  .IR_LED_DRIVE_OUTPUT(IR_LED_DRIVE_OUTPUT), .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE));

/* File: lps_frontend.sv */
`timescale 1ns/10ps
module lps_frontend
(
  input  wire logic       active,
  input  wire logic [3:0] burst,
  input  wire logic       stream,
  output logic            OSC_CLK,
  output logic            ADC_PULSE
);
  logic pulse_burst;
  wire  osc_late;
  // oscillator stands still low while idle
  initial
  begin
    OSC_CLK = 1'b0;
    pulse_burst = 1'b0;
    forever
    begin
      #200;
      OSC_CLK = active ? ~OSC_CLK : 1'b0;
    end
  end
  // a fixed burst early in each start gives an exact expected count
  always @(posedge active)
  begin
    repeat (burst)
    begin
      #310 pulse_burst = 1'b1;
      #300 pulse_burst = 1'b0;
    end
  end
  assign #100 osc_late = OSC_CLK;
  assign ADC_PULSE = stream ? osc_late : pulse_burst;
endmodule

/* File: lps_pkg.sv */
package lps_pkg;
  // apb address width and register indices; byte address is four times the index
  localparam int unsigned ADDR_W   = 8;
  localparam logic [2:0]  IDX_CMD1 = 3'h0;
  localparam logic [2:0]  IDX_CMD2 = 3'h1;
  localparam logic [2:0]  IDX_DLSB = 3'h2;
  localparam logic [2:0]  IDX_DMSB = 3'h3;
  localparam logic [2:0]  IDX_TLL  = 3'h4;
  localparam logic [2:0]  IDX_TLM  = 3'h5;
  localparam logic [2:0]  IDX_THL  = 3'h6;
  localparam logic [2:0]  IDX_THM  = 3'h7;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned IDX_MSB  = 4;

  // first command register fields
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned FLAG_BIT = 2;
  localparam int unsigned PRST_LSB = 0;
  // second command register fields
  localparam int unsigned SCHEME_BIT = 7;
  localparam int unsigned FREQ_BIT   = 6;
  localparam int unsigned IS_LSB     = 4;
  localparam int unsigned RES_LSB    = 2;
  localparam int unsigned RANGE_LSB  = 0;

  // reset values
  localparam logic [7:0]  CMD_RST    = 8'h00;
  localparam logic [15:0] DATA_RST   = 16'h0000;
  localparam logic [15:0] THR_LO_RST = 16'h0000;
  localparam logic [15:0] THR_HI_RST = 16'hffff;

  // mode codes
  localparam logic [2:0] MODE_OFF  = 3'h0;
  localparam logic [2:0] MODE_RSVD = 3'h4;
  localparam int unsigned MODE_CONT_BIT = 2;

  // sensing channels driven to the analog front end
  localparam logic [1:0] CH_AMBIENT = 2'h0;
  localparam logic [1:0] CH_IR      = 2'h1;
  localparam logic [1:0] CH_PROX    = 2'h2;

  // result and counter widths
  localparam int unsigned RES_MAX_W = 16;
  localparam int unsigned PERS_W    = 5;

  // led modulation timing
  localparam int unsigned CLK_KHZ      = 20000;
  localparam int unsigned MOD_KHZ      = 360;
  localparam int unsigned MOD_HALF_CYC = CLK_KHZ / (2 * MOD_KHZ);

  typedef enum logic {ST_OFF, ST_INTEG} seq_state_t;
endpackage
